// *** rtl/pcp_pkg.sv ***
// constants, register map and types of the position compare pulse unit
package pcp_pkg;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int DEPTH  = 64;   // compare data array words
    localparam int IDX_W  = 6;    // array index width
    localparam int ADDR_W = 6;    // register byte address width

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [5:0] OFF_CTRL   = 6'h00; // compare_control
    localparam logic [5:0] OFF_SRC    = 6'h04; // compare_source_select
    localparam logic [5:0] OFF_START  = 6'h08; // compare_array_start
    localparam logic [5:0] OFF_COUNT  = 6'h0c; // compare_point_count
    localparam logic [5:0] OFF_OFC    = 6'h10; // output_function_config
    localparam logic [5:0] OFF_WIDTH  = 6'h14; // pulse width in cycles
    localparam logic [5:0] OFF_CAPSRC = 6'h18; // capture source setting
    localparam logic [5:0] OFF_APTR   = 6'h1c; // array write pointer
    localparam logic [5:0] OFF_ADATA  = 6'h20; // array data port
    localparam logic [5:0] OFF_STAT   = 6'h24; // live status

    // ---------------------------------------------------------------
    // control field positions
    // ---------------------------------------------------------------
    localparam int CTRL_EN_BIT   = 0;  // compare enable
    localparam int CTRL_CONT_BIT = 1;  // continuous mode
    localparam int CTRL_NC_BIT   = 2;  // normally-closed output

    // ---------------------------------------------------------------
    // source codes
    // ---------------------------------------------------------------
    localparam logic [1:0] SRC_ENC   = 2'h0;
    localparam logic [1:0] SRC_AUX   = 2'h1;
    localparam logic [1:0] SRC_PULSE = 2'h2;
    localparam logic [1:0] SRC_CAP   = 2'h3;

    // ---------------------------------------------------------------
    // values after reset and forced values
    // ---------------------------------------------------------------
    localparam logic [2:0]  CTRL_RST   = 3'h0;
    localparam logic [1:0]  SRC_RST    = 2'h0;
    localparam logic [15:0] OFC_FORCED = 16'h0100;
    localparam logic [15:0] OFC_RST    = 16'h0000;
    localparam logic [15:0] WIDTH_RST  = 16'h00fa;
    localparam logic [15:0] COUNT_RST  = 16'h0000;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_NS   = 4;      // core clock period
    localparam int RESP_NS  = 5000;   // longest match-to-pulse time
    localparam int RESP_CYC = RESP_NS / CLK_NS; // rounds down

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_ARM,
        ST_WATCH,
        ST_PULSE
    } pcp_state_t;

endpackage

// *** rtl/pcp_cross_det.sv ***
// crossing detector: flags when a position passes a target value
`timescale 1ns/1ps
module pcp_cross_det (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        arm_in,
    input  wire logic [31:0] pos_in,
    input  wire logic [31:0] target_in,
    output logic             hit_out
);
    logic [31:0] prev_r;
    logic [31:0] prev_nxt;
    logic        valid_r;
    logic        valid_nxt;
    logic signed [31:0] p;
    logic signed [31:0] q;
    logic signed [31:0] t;

    // ---------------------------------------------------------------
    // crossing test on signed positions
    // ---------------------------------------------------------------
    always_comb begin
        p = $signed(pos_in);
        q = $signed(prev_r);
        t = $signed(target_in);
        // arm drops history so an old sample cannot fake a crossing
        prev_nxt  = pos_in;
        valid_nxt = ~arm_in;
        hit_out   = valid_r && ((p == t) ||
                    (q < t && p >= t) || (q > t && p <= t));
    end

    // history register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_r  <= 32'h0;
            valid_r <= 1'b0;
        end else begin
            prev_r  <= prev_nxt;
            valid_r <= valid_nxt;
        end
    end
endmodule

// *** rtl/pcp_pulse_gen.sv ***
// pulse generator: one pulse of set width and selectable polarity
`timescale 1ns/1ps
module pcp_pulse_gen (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        start_in,
    input  wire logic [15:0] width_in,
    input  wire logic        nc_in,
    output logic             pulse_out,
    output logic             busy_out
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        act_r;
    logic        act_nxt;
    logic        out_nxt;

    // ---------------------------------------------------------------
    // width counter, zero width still gives one cycle
    // ---------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        act_nxt = act_r;
        if (start_in && !act_r) begin
            act_nxt = 1'b1;
            cnt_nxt = (width_in == 16'h0) ? 16'h1 : width_in;
        end else if (act_r) begin
            cnt_nxt = cnt_r - 16'h1;
            act_nxt = (cnt_r != 16'h1);
        end
        // active level flips for normally-closed contact
        out_nxt = act_nxt ^ nc_in;
    end

    // registered output so the pin is glitch free
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r     <= 16'h0;
            act_r     <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            act_r     <= act_nxt;
            pulse_out <= out_nxt;
        end
    end

    assign busy_out = act_r;
endmodule

// *** rtl/pcp_compare_top.sv ***
// position compare unit: registers, data array, sequencer
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

// Function
// - compare selected axis position with stored targets, pulse at once
// - source: motor encoder, linear scale, pulse train or capture axis
// - capture source setting locked while capture axis is compare source
// - source select readable; software should set it before enabling
// - output pulse appears within 5 us of the match
// - on enable output-function setting forced to 0x0100, other outputs off
// - forced output-function value never stored; power-up restores default
// - output polarity selectable normally-open or normally-closed
// - several stored points compared in sequence, one pulse per match
// - pulse width set by a register
// - output driven only by hardware compare path, no software drive
// - match when source position passes through current compare value
// - count decrements per point; at zero enable clears if not continuous
// - continuous mode restarts from first entry and keeps enable set
// - enable with zero count does nothing and clears enable
module pcp_compare_top (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [5:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [31:0]      reg_rdata_out,
    input  wire logic [31:0] enc_pos_in,
    input  wire logic [31:0] aux_pos_in,
    input  wire logic [31:0] pulse_pos_in,
    input  wire logic [31:0] cap_pos_in,
    output logic             compare_pulse_output_out,
    output logic             gen_do_en_out,
    output logic [1:0]       cap_src_out,
    output logic [15:0]      ofc_nv_out
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    pcp_pkg::pcp_state_t state_r;
    pcp_pkg::pcp_state_t state_nxt;
    logic [2:0]  ctrl_r;
    logic [2:0]  ctrl_nxt;
    logic [1:0]  src_r;
    logic [1:0]  src_nxt;
    logic [1:0]  capsrc_r;
    logic [1:0]  capsrc_nxt;
    logic [5:0]  start_r;
    logic [5:0]  start_nxt;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [15:0] count_init_r;
    logic [15:0] count_init_nxt;
    logic [15:0] ofc_r;
    logic [15:0] ofc_nxt;
    logic [15:0] ofc_nv_r;
    logic [15:0] ofc_nv_nxt;
    logic [15:0] width_r;
    logic [15:0] width_nxt;
    logic [5:0]  aptr_r;
    logic [5:0]  aptr_nxt;
    logic [5:0]  idx_r;
    logic [5:0]  idx_nxt;
    logic [31:0] target_r;
    logic [31:0] target_nxt;
    logic        fire_r;
    logic        fire_nxt;
    logic        arm_r;
    logic        arm_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        gen_do_r;
    logic        gen_do_nxt;
    logic [31:0] mem [pcp_pkg::DEPTH];

    logic [31:0] live_pos;
    logic        hit;
    logic        pulse_busy;
    logic        running;
    logic        wr_ctrl;

    // ---------------------------------------------------------------
    // source mux and submodules
    // ---------------------------------------------------------------
    always_comb begin
        case (src_r)
            pcp_pkg::SRC_ENC:   live_pos = enc_pos_in;
            pcp_pkg::SRC_AUX:   live_pos = aux_pos_in;
            pcp_pkg::SRC_PULSE: live_pos = pulse_pos_in;
            default:            live_pos = cap_pos_in;
        endcase
    end

    pcp_cross_det u_det (
        .clk_in    (core_clk_in),
        .rst_n_in  (rst_n_in),
        .arm_in    (arm_r),
        .pos_in    (live_pos),
        .target_in (target_r),
        .hit_out   (hit)
    );

    // only the sequencer's fire strobe reaches the pin
    pcp_pulse_gen u_pulse (
        .clk_in    (core_clk_in),
        .rst_n_in  (rst_n_in),
        .start_in  (fire_r),
        .width_in  (width_r),
        .nc_in     (ctrl_r[pcp_pkg::CTRL_NC_BIT]),
        .pulse_out (compare_pulse_output_out),
        .busy_out  (pulse_busy)
    );

    assign running = (state_r != pcp_pkg::ST_IDLE);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == pcp_pkg::OFF_CTRL);

    // ---------------------------------------------------------------
    // register writes and sequencer next state
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt      = state_r;
        ctrl_nxt       = ctrl_r;
        src_nxt        = src_r;
        capsrc_nxt     = capsrc_r;
        start_nxt      = start_r;
        count_nxt      = count_r;
        count_init_nxt = count_init_r;
        ofc_nxt        = ofc_r;
        ofc_nv_nxt     = ofc_nv_r;
        width_nxt      = width_r;
        aptr_nxt       = aptr_r;
        idx_nxt        = idx_r;
        target_nxt     = target_r;
        fire_nxt       = 1'b0;
        arm_nxt        = 1'b0;

        // sequencer first, so a software write below wins the cycle, save the forced output setting at run start
        case (state_r)
            pcp_pkg::ST_IDLE: begin
                if (ctrl_r[pcp_pkg::CTRL_EN_BIT]) begin
                    if (count_r == 16'h0) begin
                        ctrl_nxt[pcp_pkg::CTRL_EN_BIT] = 1'b0;
                    end else begin
                        ofc_nxt        = pcp_pkg::OFC_FORCED;
                        count_init_nxt = count_r;
                        idx_nxt        = start_r;
                        state_nxt      = pcp_pkg::ST_LOAD;
                    end
                end
            end
            pcp_pkg::ST_LOAD: begin
                target_nxt = mem[idx_r];
                arm_nxt    = 1'b1;
                state_nxt  = pcp_pkg::ST_ARM;
            end
            pcp_pkg::ST_ARM: begin
                state_nxt = pcp_pkg::ST_WATCH;
            end
            pcp_pkg::ST_WATCH: begin
                if (hit) begin
                    fire_nxt  = 1'b1;
                    count_nxt = count_r - 16'h1;
                    state_nxt = pcp_pkg::ST_PULSE;
                end
            end
            pcp_pkg::ST_PULSE: begin
                // wait the full width before looking again
                if (!fire_r && !pulse_busy) begin
                    if (count_r != 16'h0) begin
                        idx_nxt   = idx_r + 6'h1;
                        state_nxt = pcp_pkg::ST_LOAD;
                    end else if (ctrl_r[pcp_pkg::CTRL_CONT_BIT]) begin
                        count_nxt = count_init_r;
                        idx_nxt   = start_r;
                        state_nxt = pcp_pkg::ST_LOAD;
                    end else begin
                        ctrl_nxt[pcp_pkg::CTRL_EN_BIT] = 1'b0;
                        state_nxt = pcp_pkg::ST_IDLE;
                    end
                end
            end
            default: state_nxt = pcp_pkg::ST_IDLE;
        endcase

        // software clearing enable aborts a run
        if (running && !ctrl_r[pcp_pkg::CTRL_EN_BIT]) begin
            state_nxt = pcp_pkg::ST_IDLE;
            fire_nxt  = 1'b0;
        end

        if (reg_wr_in) begin
            case (reg_addr_in)
                pcp_pkg::OFF_CTRL:  ctrl_nxt = reg_wdata_in[2:0];
                pcp_pkg::OFF_SRC: begin
                    // source fixed while running to keep crossings sane
                    if (!running) begin
                        src_nxt = reg_wdata_in[1:0];
                    end
                end
                pcp_pkg::OFF_CAPSRC: begin
                    if (src_r != pcp_pkg::SRC_CAP) begin
                        capsrc_nxt = reg_wdata_in[1:0];
                    end
                end
                pcp_pkg::OFF_START: start_nxt = reg_wdata_in[5:0];
                pcp_pkg::OFF_COUNT: count_nxt = reg_wdata_in[15:0];
                pcp_pkg::OFF_OFC: begin
                    // only the written value is kept for storage
                    ofc_nv_nxt = reg_wdata_in[15:0];
                    if (!running) begin
                        ofc_nxt = reg_wdata_in[15:0];
                    end
                end
                pcp_pkg::OFF_WIDTH: width_nxt = reg_wdata_in[15:0];
                pcp_pkg::OFF_APTR:  aptr_nxt  = reg_wdata_in[5:0];
                pcp_pkg::OFF_ADATA: aptr_nxt  = aptr_r + 6'h1;
                default: ;
            endcase
        end
        // a run that starts forces the live setting even over a write
        if (state_r == pcp_pkg::ST_IDLE && state_nxt == pcp_pkg::ST_LOAD) begin
            ofc_nxt = pcp_pkg::OFC_FORCED;
        end
        gen_do_nxt = (ofc_nxt != pcp_pkg::OFC_FORCED);
    end

    // ---------------------------------------------------------------
    // read data, valid the cycle after the strobe only
    // ---------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0;
        if (reg_rd_in) begin
            case (reg_addr_in)
                pcp_pkg::OFF_CTRL:   rdata_nxt = {29'h0, ctrl_r};
                pcp_pkg::OFF_SRC:    rdata_nxt = {30'h0, src_r};
                pcp_pkg::OFF_START:  rdata_nxt = {26'h0, start_r};
                pcp_pkg::OFF_COUNT:  rdata_nxt = {16'h0, count_r};
                pcp_pkg::OFF_OFC:    rdata_nxt = {16'h0, ofc_r};
                pcp_pkg::OFF_WIDTH:  rdata_nxt = {16'h0, width_r};
                pcp_pkg::OFF_CAPSRC: rdata_nxt = {30'h0, capsrc_r};
                pcp_pkg::OFF_APTR:   rdata_nxt = {26'h0, aptr_r};
                pcp_pkg::OFF_ADATA:  rdata_nxt = mem[aptr_r];
                pcp_pkg::OFF_STAT:   rdata_nxt = {16'h0, idx_r,
                                        7'h0, pulse_busy, running,
                                        compare_pulse_output_out};
                default:             rdata_nxt = 32'h0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // data array, written through the pointer port
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reg_wr_in && reg_addr_in == pcp_pkg::OFF_ADATA) begin
            mem[aptr_r] <= reg_wdata_in;
        end
    end

    // ---------------------------------------------------------------
    // register bank
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r      <= pcp_pkg::ST_IDLE;
            ctrl_r       <= pcp_pkg::CTRL_RST;
            src_r        <= pcp_pkg::SRC_RST;
            capsrc_r     <= pcp_pkg::SRC_RST;
            start_r      <= 6'h0;
            count_r      <= pcp_pkg::COUNT_RST;
            count_init_r <= pcp_pkg::COUNT_RST;
            ofc_r        <= pcp_pkg::OFC_RST;
            ofc_nv_r     <= pcp_pkg::OFC_RST;
            width_r      <= pcp_pkg::WIDTH_RST;
            aptr_r       <= 6'h0;
            idx_r        <= 6'h0;
            target_r     <= 32'h0;
            fire_r       <= 1'b0;
            arm_r        <= 1'b0;
            rdata_r      <= 32'h0;
            gen_do_r     <= 1'b1;
        end else begin
            state_r      <= state_nxt;
            ctrl_r       <= ctrl_nxt;
            src_r        <= src_nxt;
            capsrc_r     <= capsrc_nxt;
            start_r      <= start_nxt;
            count_r      <= count_nxt;
            count_init_r <= count_init_nxt;
            ofc_r        <= ofc_nxt;
            ofc_nv_r     <= ofc_nv_nxt;
            width_r      <= width_nxt;
            aptr_r       <= aptr_nxt;
            idx_r        <= idx_nxt;
            target_r     <= target_nxt;
            fire_r       <= fire_nxt;
            arm_r        <= arm_nxt;
            rdata_r      <= rdata_nxt;
            gen_do_r     <= gen_do_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign gen_do_en_out = gen_do_r;
    assign cap_src_out   = capsrc_r;
    assign ofc_nv_out    = ofc_nv_r;
endmodule

// *** bench/pcp_compare_sva.sv ***
// port checker of the position compare unit, bound to its top
`timescale 1ns/1ps
module pcp_compare_sva (
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic [5:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        compare_pulse_output_out,
    input wire logic        gen_do_en_out,
    input wire logic [1:0]  cap_src_out,
    input wire logic [15:0] ofc_nv_out
);
    // ---------------------------------------------------------------
    // write decodes
    // ---------------------------------------------------------------
    logic ctrl_wr;
    logic en_wr;
    logic ofc_wr;
    logic cap_wr;
    // decoded once so the properties stay short
    assign ctrl_wr = reg_wr_in && reg_addr_in == pcp_pkg::OFF_CTRL;
    assign en_wr   = ctrl_wr && reg_wdata_in[0];
    assign ofc_wr  = reg_wr_in && reg_addr_in == pcp_pkg::OFF_OFC;
    assign cap_wr  = reg_wr_in && reg_addr_in == pcp_pkg::OFF_CAPSRC;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    chk_read_slot: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside its slot");
    chk_unmapped_zero: assert property (
        reg_rd_in && reg_addr_in > 6'h24 |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_status_pin: assert property (
        reg_rd_in && reg_addr_in == pcp_pkg::OFF_STAT
        |=> reg_rdata_out[0] == $past(compare_pulse_output_out))
        else $error("status pin level wrong");
    // the pin may only move by hardware, or after a polarity write
    chk_pin_hw_only: assert property (
        $changed(compare_pulse_output_out) && !$past(ctrl_wr)
        && !$past(ctrl_wr, 2) |-> !gen_do_en_out)
        else $error("pin moved outside compare");
    chk_force_on: assert property (
        $fell(gen_do_en_out) |-> $past(en_wr, 2) || $past(en_wr, 3))
        else $error("outputs disabled without enable");
    chk_force_held: assert property (
        !gen_do_en_out |=> !gen_do_en_out)
        else $error("forced output setting released");
    chk_nv_software: assert property (
        $changed(ofc_nv_out) |-> $past(ofc_wr)
        && ofc_nv_out == $past(reg_wdata_in[15:0]))
        else $error("stored output setting not from software");
    chk_capsrc_write: assert property (
        $changed(cap_src_out) |-> $past(cap_wr)
        && cap_src_out == $past(reg_wdata_in[1:0]))
        else $error("capture source changed wrongly");
endmodule

bind pcp_compare_top pcp_compare_sva i_pcp_compare_sva (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .gen_do_en_out(gen_do_en_out),
    .compare_pulse_output_out(compare_pulse_output_out),
    .cap_src_out(cap_src_out), .ofc_nv_out(ofc_nv_out));

// *** bench/pcp_pulse_rx.sv ***
// receiver model: counts compare pulses and measures each width
`timescale 1ns/1ps
module pcp_pulse_rx (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    input  wire logic nc_in,
    output int        pulses_out,
    output int        width_out
);
    int run;
    // active level is the inverse of the idle level chosen by nc
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run <= 0;
            pulses_out <= 0;
            width_out <= 0;
        end else if (pin_in ^ nc_in) begin
            run <= run + 1;
            if (run == 0) begin
                pulses_out <= pulses_out + 1;
            end
        end else if (run != 0) begin
            width_out <= run;
            run <= 0;
        end
    end
endmodule

// *** bench/pcp_compare_top_tb.sv ***
// self-checking bench of the position compare unit
`timescale 1ns/1ps
module pcp_compare_top_tb;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  addr = 6'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] pos [4] = '{default: 32'h0};
    logic        pin;
    logic        gen_do;
    logic [1:0]  cap_src;
    logic [15:0] ofc_nv;
    logic        nc = 1'b0;
    int          pulses;
    int          width;
    int          bad_count = 0;
    int          compares = 0;
    int          cyc = 0;

    always #2 clk = ~clk;

    pcp_compare_top i_pcp_compare_top (
        .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .enc_pos_in(pos[0]), .aux_pos_in(pos[1]),
        .pulse_pos_in(pos[2]), .cap_pos_in(pos[3]),
        .compare_pulse_output_out(pin), .gen_do_en_out(gen_do),
        .cap_src_out(cap_src), .ofc_nv_out(ofc_nv));
    pcp_pulse_rx i_pcp_pulse_rx (
        .clk_in(clk), .rst_n_in(rst_n), .pin_in(pin), .nc_in(nc),
        .pulses_out(pulses), .width_out(width));

    // ---------------------------------------------------------------
    // bus cycles and comparison
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    // each access waits an edge first, so strobes never clash
    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e,
                          input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(what, e, rdata);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("gen_do_en", 32'h1, {31'h0, gen_do});
        chk("ofc_nv", 32'h0, {16'h0, ofc_nv});
        rd_chk(pcp_pkg::OFF_OFC, 32'h0, "ofc");
        rd_chk(pcp_pkg::OFF_WIDTH, {16'h0, pcp_pkg::WIDTH_RST}, "wid");
        rd_chk(6'h3c, 32'h0, "unmapped");
    endtask
    task automatic t_zero;
        wr_reg(pcp_pkg::OFF_OFC, 32'h5);
        wr_reg(pcp_pkg::OFF_COUNT, 32'h0);
        wr_reg(pcp_pkg::OFF_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        rd_chk(pcp_pkg::OFF_CTRL, 32'h0, "ctrl");
        chk("gen_do_en", 32'h1, {31'h0, gen_do});
    endtask
    // targets 100, 200, 300; each jump of the axis passes one target
    task automatic t_run(input logic [1:0] s, input logic [15:0] w,
                         input logic n_c, c, input int n);
        int p0;
        int t;
        int tg;
        logic [31:0] wx;
        wx = (w == 16'h0) ? 32'h1 : {16'h0, w};
        wr_reg(pcp_pkg::OFF_APTR, 32'h0);
        for (int k = 0; k < 3; k++) wr_reg(pcp_pkg::OFF_ADATA, 32'(100*k+100));
        pos[s] <= 32'h0;
        wr_reg(pcp_pkg::OFF_SRC, {30'h0, s});
        rd_chk(pcp_pkg::OFF_SRC, {30'h0, s}, "src");
        wr_reg(pcp_pkg::OFF_START, 32'h0);
        wr_reg(pcp_pkg::OFF_COUNT, 32'(n));
        wr_reg(pcp_pkg::OFF_WIDTH, {16'h0, w});
        wr_reg(pcp_pkg::OFF_CTRL, {29'h0, n_c, c, 1'b0});
        repeat (3) @(posedge clk);
        nc <= n_c;
        p0 = pulses;
        wr_reg(pcp_pkg::OFF_CTRL, {29'h0, n_c, c, 1'b1});
        for (int k = 0; k < n + int'(c); k++) begin
            repeat (8) @(posedge clk);
            tg = 100 * (k % n) + 100;
            pos[s] <= 32'((k < n) ? tg + 1 : tg - 1);
            t = 0;
            while (pin === nc && t <= pcp_pkg::RESP_CYC) begin
                @(posedge clk);
                #1;
                t++;
            end
            chk("late", 32'h0, {31'h0, t > pcp_pkg::RESP_CYC});
            while (pin !== nc) begin
                @(posedge clk);
                #1;
            end
            @(posedge clk);
            #1 chk("width", wx, width);
        end
        repeat (4) @(posedge clk);
        chk("pulses", 32'(n + int'(c)), 32'(pulses - p0));
        rd_chk(pcp_pkg::OFF_CTRL, {29'h0, n_c, c, c}, "ctrl");
        if (!c) rd_chk(pcp_pkg::OFF_COUNT, 32'h0, "count");
        if (c) wr_reg(pcp_pkg::OFF_CTRL, {29'h0, n_c, c, 1'b0});
        #1 chk("pin idle", {31'h0, n_c}, {31'h0, pin});
        rd_chk(pcp_pkg::OFF_STAT, {16'h0, 6'(n-1), 9'h0, n_c}, "sts");
    endtask
    task automatic t_capsrc;
        wr_reg(pcp_pkg::OFF_CAPSRC, 32'h2);
        rd_chk(pcp_pkg::OFF_CAPSRC, 32'h0, "capsrc locked");
        wr_reg(pcp_pkg::OFF_SRC, {30'h0, pcp_pkg::SRC_ENC});
        wr_reg(pcp_pkg::OFF_CAPSRC, 32'h2);
        rd_chk(pcp_pkg::OFF_CAPSRC, 32'h2, "capsrc free");
        chk("cap_src", 32'h2, {30'h0, cap_src});
    endtask

    // ---------------------------------------------------------------
    // verdict, hang guard and main sequence
    // ---------------------------------------------------------------
    task automatic summarize;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // whole run needs roughly a thousand cycles; this ceiling is generous
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        do_reset();
        t_zero();
        t_run(pcp_pkg::SRC_ENC, 16'h0, 1'b0, 1'b0, 3);
        chk("ofc_nv", 32'h5, {16'h0, ofc_nv});
        chk("gen_do_en", 32'h0, {31'h0, gen_do});
        rd_chk(pcp_pkg::OFF_OFC, 32'h100, "ofc forced");
        t_run(pcp_pkg::SRC_AUX, 16'h5, 1'b1, 1'b0, 2);
        t_run(pcp_pkg::SRC_PULSE, pcp_pkg::WIDTH_RST, 1'b0, 1'b1, 2);
        t_run(pcp_pkg::SRC_CAP, 16'h1, 1'b1, 1'b0, 1);
        t_capsrc();
        do_reset();
        summarize();
    end
endmodule
